// ==== design/tlv_ext_det.sv ====
// module: edge or level detector with its flag for one external interrupt pin
`timescale 1ns/1ps
module tlv_ext_det #(
  parameter bit ACTIVE_LOW = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  tlv_ext_if.det ext
);
  logic active;
  logic prev_ff;
  logic flag_ff;
  logic edge_seen;

  // a low pin is the request for the _n pins, a high one otherwise
  assign active = ACTIVE_LOW ? ~ext.pin : ext.pin;
  assign edge_seen = ext.sample & active & ~prev_ff;
  assign ext.flag = flag_ff;

  // previous sample, taken once per machine cycle only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev_ff <= 1'b0;
    else if (ext.sample)
      prev_ff <= active;
  end

  // level mode mirrors the pin; edge mode holds until cleared, a new edge beats a clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flag_ff <= 1'b0;
    else if (!ext.edge_mode)
    begin
      if (ext.sample)
        flag_ff <= active;
    end
    else if (edge_seen)
      flag_ff <= 1'b1;
    else if (ext.sw_wr)
      flag_ff <= ext.sw_val;
    else if (ext.hw_clr)
      flag_ff <= 1'b0;
  end

  a_edge_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    ext.edge_mode && edge_seen |=> flag_ff)
    else $error("edge did not set the flag");
  a_level_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
    !ext.edge_mode && ext.sample |=> flag_ff == $past(active))
    else $error("level flag does not follow the pin");
endmodule

// ==== design/tlv_ext_if.sv ====
// interface: one external interrupt pin detector and its controls
`timescale 1ns/1ps
interface tlv_ext_if;
  logic pin;
  logic sample;
  logic edge_mode;
  logic sw_wr;
  logic sw_val;
  logic hw_clr;
  logic flag;
  modport det (input pin, input sample, input edge_mode, input sw_wr, input sw_val,
    input hw_clr, output flag);
  modport ctl (output pin, output sample, output edge_mode, output sw_wr, output sw_val,
    output hw_clr, input flag);
endinterface

// ==== design/tlv_intc.sv ====
// module: two-level vectored interrupt controller with an AXI4-Lite register port
`timescale 1ns/1ps
// Overview of operation
// - ten sources, fixed vectors 0003h to 006Bh, fixed tie-break order.
// - flags sampled each machine cycle, polled and resolved in that cycle.
// - call only if nothing equal or higher in service and last instruction cycle.
// - no call when instruction writes enable, priority, flag registers or is a return from interrupt.
// - blocked requests are not remembered; every poll starts afresh.
// - timer overflow flag cleared by hardware on vectoring to it.
// - ext0/ext1 cleared on vectoring only if edge mode; others left to software.
// - the call acts as a long call: push counter, load vector.
// - only a return from interrupt ends service; plain return does not.
// - pins sampled at S3; timer flags set at S3, polled next cycle.
// - vector call lasts four machine cycles, five at least after a flag.
// - worst response eleven machine cycles, 44 clocks, with nothing in service.
// - edge flag holds until cleared; level flag is the inverted pin.
// - trigger select 0 is level, the default; 1 is falling edge.
// - timer overflow sets its flag; software may clear it.
// - ext3 flag set on falling edge, cleared by software, settable by software.
// - ext2 flag set on rising edge, cleared by software, settable by software.
// - global enable 0, the default, blocks every interrupt.
// - adc, serial, timer and ext0/ext1 each masked by enable, default off.
// - priority bit picks low or high level; low never preempts high.
// - pwm, watchdog, ext3, ext2 masked by extended enables, default off.
module tlv_intc #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_irq0_pin_n,
  input wire logic ext_irq1_pin_n,
  input wire logic ext_irq2_pin,
  input wire logic ext_irq3_pin_n,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic serial_receive_flag,
  input wire logic serial_transmit_flag,
  input wire logic adc_int_flag,
  input wire logic watchdog_int_flag,
  input wire logic pwm_int_flag,
  input wire logic cpu_last_cycle,
  input wire logic cpu_ctl_write,
  input wire logic cpu_is_return_from_interrupt,
  output logic timer0_run,
  output logic timer1_run,
  output logic vec_call,
  output logic [15:0] vec_addr,
  output logic [1:0] in_service
);
  localparam int NS = tlv_pkg::NUM_SRC;
  localparam logic [4:0] CALL_LAST = 5'(tlv_pkg::CALL_CLKS - 1);

  if (ADDR_W < 10 || ADDR_W > 32)
  begin : g_chk
    $error("ADDR_W must lie between 10 and 32");
  end

  logic [1:0] phase_ff;
  logic [1:0] tf_ff;
  logic [1:0] tr_ff;
  logic [1:0] it_ff;
  logic [1:0] ovf_pend_ff;
  logic [7:0] ie_ff;
  logic [7:0] ip_ff;
  logic [7:0] eie_ff;
  logic [7:0] eip_ff;
  logic [NS-1:0] snap_ff;
  logic [1:0] isv_ff;
  tlv_pkg::tlv_call_t call_st_ff;
  logic [4:0] call_cnt_ff;
  logic vec_call_ff;
  logic [15:0] vec_addr_ff;
  logic awready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  logic [3:0] ext_flag;
  logic [NS-1:0] raw_flags;
  logic [NS-1:0] en_vec;
  logic [NS-1:0] pri_vec;
  logic [NS-1:0] req_hi;
  logic [NS-1:0] req_lo;
  logic pick_valid;
  logic pick_lvl;
  logic [3:0] pick_idx;
  logic poll;
  logic return_from_interrupt_now;
  logic tf_set0;
  logic tf_set1;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic wr_hit;
  logic rd_hit;
  logic wr_lane;
  logic timer_ext_int_control_wr;
  logic extra_ext_int_flags_wr;
  logic [7:0] timer_ext_int_control_rd;
  logic [7:0] extra_ext_int_flags_rd;
  logic [7:0] stat_rd;
  logic [7:0] rd_val;

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = awready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign timer0_run = tr_ff[0];
  assign timer1_run = tr_ff[1];
  assign vec_call = vec_call_ff;
  assign vec_addr = vec_addr_ff;
  assign in_service = isv_ff;

  // machine cycle phase, four clocks S1..S4
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase_ff <= 2'h0;
    else
      phase_ff <= phase_ff + 2'h1;
  end

  // bus decode; byte address is index times four, upper bits must be zero
  assign wr_fire = awready_ff;
  assign wr_idx = s_axi_awaddr[9:2];
  assign rd_idx = s_axi_araddr[9:2];
  assign wr_lane = s_axi_wstrb[0];
  always_comb
  begin
    wr_hit = (s_axi_awaddr[1:0] == 2'h0) && (s_axi_awaddr >> 10 == '0);
    rd_hit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr >> 10 == '0);
    case (wr_idx)
      tlv_pkg::IDX_TIMER_EXT_INT_CONTROL, tlv_pkg::IDX_EXTRA_EXT_INT_FLAGS,
      tlv_pkg::IDX_INT_ENABLE, tlv_pkg::IDX_INT_PRIORITY, tlv_pkg::IDX_EXT_INT_ENABLE,
      tlv_pkg::IDX_EXT_INT_PRIORITY, tlv_pkg::IDX_SERVICE_STATUS: ;
      default: wr_hit = 1'b0;
    endcase
    case (rd_idx)
      tlv_pkg::IDX_TIMER_EXT_INT_CONTROL, tlv_pkg::IDX_EXTRA_EXT_INT_FLAGS,
      tlv_pkg::IDX_INT_ENABLE, tlv_pkg::IDX_INT_PRIORITY, tlv_pkg::IDX_EXT_INT_ENABLE,
      tlv_pkg::IDX_EXT_INT_PRIORITY, tlv_pkg::IDX_SERVICE_STATUS: ;
      default: rd_hit = 1'b0;
    endcase
  end
  assign timer_ext_int_control_wr = wr_fire && wr_hit && wr_lane && wr_idx == tlv_pkg::IDX_TIMER_EXT_INT_CONTROL;
  assign extra_ext_int_flags_wr = wr_fire && wr_hit && wr_lane && wr_idx == tlv_pkg::IDX_EXTRA_EXT_INT_FLAGS;

  // write channel: address and data taken together, one write at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= tlv_pkg::RESP_OKAY;
    end
    else
    begin
      awready_ff <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
      if (wr_fire)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? tlv_pkg::RESP_OKAY : tlv_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // read-back images of the flag and status registers
  always_comb
  begin
    timer_ext_int_control_rd = '0;
    timer_ext_int_control_rd[tlv_pkg::TC_TF1] = tf_ff[1];
    timer_ext_int_control_rd[tlv_pkg::TC_TR1] = tr_ff[1];
    timer_ext_int_control_rd[tlv_pkg::TC_TF0] = tf_ff[0];
    timer_ext_int_control_rd[tlv_pkg::TC_TR0] = tr_ff[0];
    timer_ext_int_control_rd[tlv_pkg::TC_IE1] = ext_flag[1];
    timer_ext_int_control_rd[tlv_pkg::TC_IT1] = it_ff[1];
    timer_ext_int_control_rd[tlv_pkg::TC_IE0] = ext_flag[0];
    timer_ext_int_control_rd[tlv_pkg::TC_IT0] = it_ff[0];
    extra_ext_int_flags_rd = '0;
    extra_ext_int_flags_rd[tlv_pkg::XF_IE3] = ext_flag[3];
    extra_ext_int_flags_rd[tlv_pkg::XF_IE2] = ext_flag[2];
    stat_rd = '0;
    stat_rd[tlv_pkg::ST_ISV_LO] = isv_ff[0];
    stat_rd[tlv_pkg::ST_ISV_HI] = isv_ff[1];
    stat_rd[tlv_pkg::ST_BUSY] = vec_call_ff;
    case (rd_idx)
      tlv_pkg::IDX_TIMER_EXT_INT_CONTROL: rd_val = timer_ext_int_control_rd;
      tlv_pkg::IDX_EXTRA_EXT_INT_FLAGS: rd_val = extra_ext_int_flags_rd;
      tlv_pkg::IDX_INT_ENABLE: rd_val = ie_ff;
      tlv_pkg::IDX_INT_PRIORITY: rd_val = ip_ff;
      tlv_pkg::IDX_EXT_INT_ENABLE: rd_val = eie_ff;
      tlv_pkg::IDX_EXT_INT_PRIORITY: rd_val = eip_ff;
      tlv_pkg::IDX_SERVICE_STATUS: rd_val = stat_rd;
      default: rd_val = '0;
    endcase
  end

  // read channel: one read at a time, data registered with the valid
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= tlv_pkg::RESP_OKAY;
    end
    else
    begin
      arready_ff <= s_axi_arvalid && !arready_ff && !rvalid_ff;
      if (arready_ff)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff <= {24'h000000, rd_hit ? rd_val : 8'h00};
        rresp_ff <= rd_hit ? tlv_pkg::RESP_OKAY : tlv_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  // plain software registers; reserved bits stay zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ie_ff <= tlv_pkg::REG_RESET;
      ip_ff <= tlv_pkg::REG_RESET;
      eie_ff <= tlv_pkg::REG_RESET;
      eip_ff <= tlv_pkg::REG_RESET;
      tr_ff <= 2'h0;
      it_ff <= 2'h0;
    end
    else if (wr_fire && wr_hit && wr_lane)
    begin
      case (wr_idx)
        tlv_pkg::IDX_INT_ENABLE: ie_ff <= s_axi_wdata[7:0] & tlv_pkg::EN_MASK;
        tlv_pkg::IDX_INT_PRIORITY: ip_ff <= s_axi_wdata[7:0] & tlv_pkg::PRI_MASK;
        tlv_pkg::IDX_EXT_INT_ENABLE: eie_ff <= s_axi_wdata[7:0] & tlv_pkg::XEN_MASK;
        tlv_pkg::IDX_EXT_INT_PRIORITY: eip_ff <= s_axi_wdata[7:0] & tlv_pkg::XEN_MASK;
        tlv_pkg::IDX_TIMER_EXT_INT_CONTROL:
        begin
          tr_ff <= {s_axi_wdata[tlv_pkg::TC_TR1], s_axi_wdata[tlv_pkg::TC_TR0]};
          it_ff <= {s_axi_wdata[tlv_pkg::TC_IT1], s_axi_wdata[tlv_pkg::TC_IT0]};
        end
        default: ;
      endcase
    end
  end

  // overflow pulses wait for S3; a set beats a software clear and the vector clear
  assign tf_set0 = phase_ff == tlv_pkg::PH_S3 && (ovf_pend_ff[0] || timer0_overflow);
  assign tf_set1 = phase_ff == tlv_pkg::PH_S3 && (ovf_pend_ff[1] || timer1_overflow);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovf_pend_ff <= 2'h0;
      tf_ff <= 2'h0;
    end
    else
    begin
      if (phase_ff == tlv_pkg::PH_S3)
        ovf_pend_ff <= 2'h0;
      else
        ovf_pend_ff <= ovf_pend_ff | {timer1_overflow, timer0_overflow};
      if (tf_set0)
        tf_ff[0] <= 1'b1;
      else if (timer_ext_int_control_wr)
        tf_ff[0] <= s_axi_wdata[tlv_pkg::TC_TF0];
      else if (poll && pick_idx == tlv_pkg::SRC_T0)
        tf_ff[0] <= 1'b0;
      if (tf_set1)
        tf_ff[1] <= 1'b1;
      else if (timer_ext_int_control_wr)
        tf_ff[1] <= s_axi_wdata[tlv_pkg::TC_TF1];
      else if (poll && pick_idx == tlv_pkg::SRC_T1)
        tf_ff[1] <= 1'b0;
    end
  end

  // four external pin detectors; ext2 and ext3 are edge only
  localparam int EXT_SRC [4] = '{0, 2, 6, 7};
  localparam int EXT_BIT [4] = '{tlv_pkg::TC_IE0, tlv_pkg::TC_IE1, tlv_pkg::XF_IE2,
    tlv_pkg::XF_IE3};
  logic [3:0] ext_pins;
  assign ext_pins = {ext_irq3_pin_n, ext_irq2_pin, ext_irq1_pin_n, ext_irq0_pin_n};
  tlv_ext_if ext_if [4] ();
  for (genvar g = 0; g < 4; g++)
  begin : g_ext
    assign ext_if[g].pin = ext_pins[g];
    assign ext_if[g].sample = phase_ff == tlv_pkg::PH_S3;
    assign ext_if[g].edge_mode = (g < 2) ? it_ff[g % 2] : 1'b1;
    assign ext_if[g].sw_wr = (g < 2) ? timer_ext_int_control_wr : extra_ext_int_flags_wr;
    assign ext_if[g].sw_val = s_axi_wdata[EXT_BIT[g]];
    assign ext_if[g].hw_clr = (g < 2) && poll && pick_idx == 4'(EXT_SRC[g]);
    assign ext_flag[g] = ext_if[g].flag;
    tlv_ext_det #(
      .ACTIVE_LOW(g != 2)
    ) u_det (
      .aclk(aclk),
      .aresetn(aresetn),
      .ext(ext_if[g])
    );
  end

  // request, enable and priority vectors in tie-break order
  always_comb
  begin
    raw_flags = {pwm_int_flag, watchdog_int_flag, ext_flag[3], ext_flag[2], adc_int_flag,
      serial_receive_flag | serial_transmit_flag, tf_ff[1], ext_flag[1], tf_ff[0], ext_flag[0]};
    en_vec = {eie_ff[tlv_pkg::XE_PWM], eie_ff[tlv_pkg::XE_WDT], eie_ff[tlv_pkg::XE_X3],
      eie_ff[tlv_pkg::XE_X2], ie_ff[tlv_pkg::EN_ADC], ie_ff[tlv_pkg::EN_SER],
      ie_ff[tlv_pkg::EN_T1], ie_ff[tlv_pkg::EN_X1], ie_ff[tlv_pkg::EN_T0],
      ie_ff[tlv_pkg::EN_X0]};
    pri_vec = {eip_ff[tlv_pkg::XE_PWM], eip_ff[tlv_pkg::XE_WDT], eip_ff[tlv_pkg::XE_X3],
      eip_ff[tlv_pkg::XE_X2], ip_ff[tlv_pkg::EN_ADC], ip_ff[tlv_pkg::EN_SER],
      ip_ff[tlv_pkg::EN_T1], ip_ff[tlv_pkg::EN_X1], ip_ff[tlv_pkg::EN_T0],
      ip_ff[tlv_pkg::EN_X0]};
  end

  // flags sampled at S2 so that S3 sets are seen one machine cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      snap_ff <= '0;
    else if (phase_ff == tlv_pkg::PH_S2)
      snap_ff <= raw_flags;
  end

  // resolve: high level before low, lowest index wins within a level
  always_comb
  begin
    req_hi = snap_ff & en_vec & pri_vec & {NS{ie_ff[tlv_pkg::EN_GLOBAL]}};
    req_lo = snap_ff & en_vec & ~pri_vec & {NS{ie_ff[tlv_pkg::EN_GLOBAL]}};
    pick_valid = 1'b0;
    pick_lvl = 1'b0;
    pick_idx = 4'h0;
    for (int i = NS - 1; i >= 0; i--)
    begin
      if (req_lo[i] && isv_ff == 2'h0)
      begin
        pick_valid = 1'b1;
        pick_idx = 4'(i);
      end
    end
    for (int i = NS - 1; i >= 0; i--)
    begin
      if (req_hi[i] && !isv_ff[1])
      begin
        pick_valid = 1'b1;
        pick_lvl = 1'b1;
        pick_idx = 4'(i);
      end
    end
  end

  // nothing is latched: a poll that fails is simply forgotten
  assign poll = phase_ff == tlv_pkg::PH_S4 && pick_valid && cpu_last_cycle
    && !cpu_ctl_write && !cpu_is_return_from_interrupt && call_st_ff == tlv_pkg::CALL_IDLE;
  assign return_from_interrupt_now = phase_ff == tlv_pkg::PH_S4 && cpu_last_cycle && cpu_is_return_from_interrupt;

  // vector call sequencer: the core pushes the counter and loads vec_addr while it runs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      call_st_ff <= tlv_pkg::CALL_IDLE;
      call_cnt_ff <= '0;
      vec_call_ff <= 1'b0;
      vec_addr_ff <= '0;
    end
    else
    begin
      case (call_st_ff)
        tlv_pkg::CALL_IDLE:
        begin
          if (poll)
          begin
            call_st_ff <= tlv_pkg::CALL_RUN;
            call_cnt_ff <= CALL_LAST;
            vec_call_ff <= 1'b1;
            vec_addr_ff <= tlv_pkg::VEC[pick_idx];
          end
        end
        tlv_pkg::CALL_RUN:
        begin
          if (call_cnt_ff == 5'h00)
          begin
            call_st_ff <= tlv_pkg::CALL_IDLE;
            vec_call_ff <= 1'b0;
          end
          call_cnt_ff <= call_cnt_ff - 5'h01;
        end
        default: call_st_ff <= tlv_pkg::CALL_IDLE;
      endcase
    end
  end

  // in-service bits: a plain return never reaches here, only a return from interrupt
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      isv_ff <= 2'h0;
    else if (poll)
      isv_ff[pick_lvl] <= 1'b1;
    else if (return_from_interrupt_now)
    begin
      if (isv_ff[1])
        isv_ff[1] <= 1'b0;
      else
        isv_ff[0] <= 1'b0;
    end
  end

  a_call_length: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(vec_call_ff) |-> vec_call_ff [*8] ##1 vec_call_ff [*8] ##1 !vec_call_ff)
    else $error("vector call does not last four machine cycles");
  a_call_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(vec_call_ff) |-> $past(cpu_last_cycle && phase_ff == tlv_pkg::PH_S4))
    else $error("vector call outside the last S4 of an instruction");
  a_call_block: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(vec_call_ff) |-> !$past(cpu_ctl_write) && !$past(cpu_is_return_from_interrupt))
    else $error("vector call during a blocking instruction");
  a_vector_table: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(vec_call_ff) |-> vec_addr_ff == tlv_pkg::VEC[$past(pick_idx)])
    else $error("wrong vector address");
  a_no_preempt: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(isv_ff[0]) |-> $past(isv_ff) == 2'h0 && !$past(pri_vec[pick_idx]))
    else $error("low level entered over active service");
  a_global_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !ie_ff[tlv_pkg::EN_GLOBAL] |=> !$rose(vec_call_ff))
    else $error("call while globally disabled");
  a_timer_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    poll && pick_idx == tlv_pkg::SRC_T0 && !timer_ext_int_control_wr |=> !tf_ff[0])
    else $error("timer0 flag not cleared on vectoring");
  a_timer_at_s3: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tf_ff[1]) && !$past(timer_ext_int_control_wr) |-> $past(phase_ff) == tlv_pkg::PH_S3)
    else $error("timer1 flag set outside S3");
  a_return_from_interrupt_high: assert property (@(posedge aclk) disable iff (!aresetn)
    return_from_interrupt_now && isv_ff[1] |=> !isv_ff[1] && isv_ff[0] == $past(isv_ff[0]))
    else $error("return did not clear the high level only");
endmodule

// ==== design/tlv_pkg.sv ====
// package: register map, field positions, vectors and timing of the interrupt controller
package tlv_pkg;
  localparam int NUM_SRC = 10;
  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_TIMER_EXT_INT_CONTROL = 8'h88;
  localparam logic [7:0] IDX_EXTRA_EXT_INT_FLAGS = 8'h91;
  localparam logic [7:0] IDX_INT_ENABLE = 8'hA8;
  localparam logic [7:0] IDX_INT_PRIORITY = 8'hB8;
  localparam logic [7:0] IDX_EXT_INT_ENABLE = 8'hE8;
  localparam logic [7:0] IDX_EXT_INT_PRIORITY = 8'hF8;
  localparam logic [7:0] IDX_SERVICE_STATUS = 8'h10;
  localparam logic [7:0] REG_RESET = 8'h00;
  // timer/external control fields
  localparam int TC_TF1 = 7;
  localparam int TC_TR1 = 6;
  localparam int TC_TF0 = 5;
  localparam int TC_TR0 = 4;
  localparam int TC_IE1 = 3;
  localparam int TC_IT1 = 2;
  localparam int TC_IE0 = 1;
  localparam int TC_IT0 = 0;
  // extra flag fields
  localparam int XF_IE3 = 5;
  localparam int XF_IE2 = 4;
  // enable register fields; priority register uses the same positions
  localparam int EN_GLOBAL = 7;
  localparam int EN_ADC = 6;
  localparam int EN_SER = 4;
  localparam int EN_T1 = 3;
  localparam int EN_X1 = 2;
  localparam int EN_T0 = 1;
  localparam int EN_X0 = 0;
  localparam int XE_PWM = 5;
  localparam int XE_WDT = 4;
  localparam int XE_X3 = 1;
  localparam int XE_X2 = 0;
  localparam logic [7:0] EN_MASK = 8'hDF;
  localparam logic [7:0] PRI_MASK = 8'h5F;
  localparam logic [7:0] XEN_MASK = 8'h33;
  // status fields
  localparam int ST_ISV_LO = 0;
  localparam int ST_ISV_HI = 1;
  localparam int ST_BUSY = 2;
  // source numbers, highest tie-break first
  localparam logic [3:0] SRC_X0 = 4'h0;
  localparam logic [3:0] SRC_T0 = 4'h1;
  localparam logic [3:0] SRC_X1 = 4'h2;
  localparam logic [3:0] SRC_T1 = 4'h3;
  localparam logic [3:0] SRC_SER = 4'h4;
  localparam logic [3:0] SRC_ADC = 4'h5;
  localparam logic [3:0] SRC_X2 = 4'h6;
  localparam logic [3:0] SRC_X3 = 4'h7;
  localparam logic [3:0] SRC_WDT = 4'h8;
  localparam logic [3:0] SRC_PWM = 4'h9;
  localparam logic [15:0] VEC [NUM_SRC] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B,
    16'h0023, 16'h003B, 16'h0043, 16'h004B, 16'h0063, 16'h006B};
  // machine cycle phases S1..S4
  localparam logic [1:0] PH_S2 = 2'h1;
  localparam logic [1:0] PH_S3 = 2'h2;
  localparam logic [1:0] PH_S4 = 2'h3;
  localparam int CLK_PER_MC = 4;
  localparam int CALL_MC = 4;
  localparam int CALL_CLKS = CLK_PER_MC * CALL_MC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {CALL_IDLE, CALL_RUN} tlv_call_t;
endpackage

// ==== verif/tlv_cpu_model.sv ====
// core model: every machine cycle ends an instruction; a handler returns after each call
`timescale 1ns/1ps
module tlv_cpu_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic vec_call,
  output logic cpu_last_cycle,
  output logic cpu_ctl_write,
  output logic cpu_is_return_from_interrupt
);
  logic [4:0] ret_ff;
  // return one machine cycle after the call ends, so exactly one S4 sees it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ret_ff <= 5'h00;
    else if (vec_call)
      ret_ff <= 5'h08;
    else if (ret_ff != 5'h00)
      ret_ff <= ret_ff - 5'h01;
  end
  assign cpu_last_cycle = 1'b1;
  assign cpu_ctl_write = 1'b0;
  assign cpu_is_return_from_interrupt = (ret_ff != 5'h00) && (ret_ff <= 5'h04);
endmodule

// ==== verif/two_level_vectored_interrupt_ctrl_bench.sv ====
// bench: register access and timer/ext2 flags and vectoring of the interrupt controller
`timescale 1ns/1ps
module two_level_vectored_interrupt_ctrl_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ext_irq0_pin_n, ext_irq1_pin_n, ext_irq2_pin, ext_irq3_pin_n, timer0_overflow;
  logic timer1_overflow, serial_receive_flag, serial_transmit_flag, adc_int_flag;
  logic watchdog_int_flag, pwm_int_flag, cpu_last_cycle, cpu_ctl_write, cpu_is_return_from_interrupt;
  logic timer0_run, timer1_run, vec_call, vc_q;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, in_service;
  logic [15:0] vec_addr;
  logic [7:0] d;
  logic [33:0] rq[$];
  logic [33:0] vq[$];
  logic [1:0] bq[$];
  int mismatches, num_checks, len;
  tlv_intc i_tlv_intc (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_irq0_pin_n, .ext_irq1_pin_n, .ext_irq2_pin,
    .ext_irq3_pin_n, .timer0_overflow, .timer1_overflow, .serial_receive_flag,
    .serial_transmit_flag, .adc_int_flag, .watchdog_int_flag, .pwm_int_flag, .cpu_last_cycle,
    .cpu_ctl_write, .cpu_is_return_from_interrupt, .timer0_run, .timer1_run, .vec_call, .vec_addr, .in_service);
  tlv_cpu_model i_tlv_cpu_model (.aclk, .aresetn, .vec_call, .cpu_last_cycle, .cpu_ctl_write,
    .cpu_is_return_from_interrupt);
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    num_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // write one register; address and data go up together, each drops when its own ready is seen
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic aw_p, w_p;
    bq.push_back(tlv_pkg::RESP_OKAY);
    aw_p = 1'b1;
    w_p = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        aw_p = 1'b0;
      if (s_axi_wready === 1'b1)
        w_p = 1'b0;
      s_axi_awvalid <= aw_p;
      s_axi_wvalid <= w_p;
    end
    while (aw_p || w_p);
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  // read one register and note the expected response and data
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // watcher: read answers, vector calls and call length against the noted expectations
  always @(posedge aclk)
  begin
    vc_q <= vec_call;
    len <= vec_call ? len + 1 : 0;
    {serial_receive_flag, serial_transmit_flag, adc_int_flag} <= 3'($urandom);
    {watchdog_int_flag, pwm_int_flag} <= 2'($urandom);
    if (s_axi_rvalid && s_axi_rready)
      chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      chk("write resp", 34'(bq.pop_front()), 34'(s_axi_bresp));
    if (vec_call === 1'b1 && vc_q === 1'b0)
      chk("vector", vq.pop_front(), {16'h0000, in_service, vec_addr});
    if (vec_call === 1'b0 && vc_q === 1'b1)
      chk("call length", 34'(tlv_pkg::CALL_CLKS), 34'(len));
  end
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    print_verdict();
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {ext_irq2_pin, timer0_overflow, timer1_overflow} = '0;
    {ext_irq0_pin_n, ext_irq1_pin_n, ext_irq3_pin_n} = 3'h7;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {24'h000000, 32'h0, 4'hF};
    void'($urandom(32'h30AA1D6D));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h2A0, 34'h0);
    rd(12'h3A0, 34'h0);
    rd(12'h220, 34'h0);
    rd(12'h004, {2'h2, 32'h0});
    d = 8'($urandom);
    wr(12'h2E0, d);
    rd(12'h2E0, {26'h0, d & tlv_pkg::PRI_MASK});
    wr(12'h2A0, 8'h02);
    {timer0_overflow, timer1_overflow} <= 2'h3;
    @(posedge aclk);
    {timer0_overflow, timer1_overflow} <= 2'h0;
    repeat (16) @(posedge aclk);
    rd(12'h220, 34'hA0);
    vq.push_back({16'h0000, d[tlv_pkg::EN_T0] ? 2'b10 : 2'b01, 16'h000B});
    wr(12'h2A0, 8'h82);
    wait (vq.size() == 0);
    @(posedge aclk);
    wait (in_service === 2'b00);
    wr(12'h2A0, 8'h00);
    rd(12'h220, 34'h80);
    wr(12'h3A0, 8'h01);
    ext_irq2_pin <= 1'b1;
    repeat (16) @(posedge aclk);
    rd(12'h244, 34'h10);
    wr(12'h220, 8'h50);
    rd(12'h220, 34'h50);
    wr(12'h220, 8'h51);
    ext_irq0_pin_n <= 1'b0;
    repeat (16) @(posedge aclk);
    rd(12'h220, 34'h53);
    chk("run bits", 34'h3, {32'h0, timer1_run, timer0_run});
    print_verdict();
  end
endmodule
